// ---- core/tc16_pkg.sv ----
// Purpose: shared constants and types of the 16-bit timer/counter
// Assumes: classic wishbone slave, 32-bit data, byte addresses
// Notes:   registers sit in the low byte of each word
`default_nettype none
package tc16_pkg;
    // register byte addresses
    localparam logic [7:0] ADR_CONTROL = 8'h00;
    localparam logic [7:0] ADR_LOW     = 8'h04;
    localparam logic [7:0] ADR_HIGH    = 8'h08;
    localparam logic [7:0] ADR_STATUS  = 8'h0c;
    // counter_control field positions
    localparam int BIT_RUN   = 0;
    localparam int BIT_CSEL  = 1;
    localparam int BIT_NSYNC = 2;
    localparam int BIT_OSCEN = 3;
    localparam int BIT_PS_LO = 4;
    localparam int BIT_PS_HI = 5;
    localparam int BIT_UNIMP = 6;
    localparam int BIT_WIDE  = 7;
    // status fields
    localparam int BIT_FLAG  = 0;
    localparam int BIT_IEN   = 1;
    // reset values and masks
    localparam logic [7:0]  CONTROL_RST = 8'h00;
    localparam logic [7:0]  CONTROL_WR_MASK = 8'hbf;
    localparam logic [15:0] COUNT_RST   = 16'h0000;
    localparam logic [15:0] COUNT_MAX   = 16'hffff;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    // instruction cycle is four system clocks (fosc/4)
    localparam int          INSTR_DIV   = 4;
    localparam logic [1:0]  INSTR_LAST  = 2'(INSTR_DIV - 1);
    // operating modes
    typedef enum logic [2:0] {
        MODE_TIMER = 3'b001,
        MODE_SYNC  = 3'b010,
        MODE_ASYNC = 3'b100
    } mode_t;
    // wishbone request from the master
    typedef struct packed {
        logic        cyc;
        logic        stb;
        logic        we;
        logic [7:0]  adr;
        logic [3:0]  sel;
        logic [31:0] dat;
    } wb_req_t;
    // wishbone answer to the master
    typedef struct packed {
        logic        ack;
        logic [31:0] dat;
    } wb_rsp_t;
endpackage
`default_nettype wire

// ---- core/edge_sync.sv ----
// Purpose: rising edge detect of a pin, synchronised or raw
// Assumes: pin is sampled on clk
// Notes:   the first stage feeds only the second stage
`default_nettype none
module edge_sync
    import tc16_pkg::*;
(
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic pin,
    input  wire logic bypass,
    output logic      rise
);
    logic meta_ff;   // first stage, read only by sync_ff
    logic sync_ff;   // second stage
    logic sprev_ff;  // previous synchronised level
    logic rprev_ff;  // previous raw level, for bypass

    // two-stage synchroniser and edge history
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_ff  <= 1'b0;
            sync_ff  <= 1'b0;
            sprev_ff <= 1'b0;
            rprev_ff <= 1'b0;
        end else begin
            meta_ff  <= pin;
            sync_ff  <= meta_ff;
            sprev_ff <= sync_ff;
            rprev_ff <= pin;
        end
    end

    // bypass saves two cycles of latency but trusts the pin timing
    assign rise = bypass ? (pin & ~rprev_ff) : (sync_ff & ~sprev_ff);
endmodule
`default_nettype wire

// ---- core/prescale_div.sv ----
// Purpose: 1/2/4/8 prescaler on input ticks
// Assumes: tick_in is a one-cycle pulse
// Notes:   clear wins over a coincident tick
`default_nettype none
module prescale_div
    import tc16_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic       tick_in,
    input  wire logic [1:0] ratio,
    input  wire logic       clear,
    output logic            tick_out
);
    logic [2:0] cnt_ff;   // ticks seen since last output
    logic [2:0] limit;    // last count before an output

    // encodings 00..11 give 1:1, 1:2, 1:4, 1:8
    assign limit    = 3'((4'h1 << ratio) - 4'h1);
    assign tick_out = tick_in & (cnt_ff == limit) & ~clear;

    // count input ticks, wrap on the output tick
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_ff <= 3'h0;
        end else if (clear) begin
            cnt_ff <= 3'h0;
        end else if (tick_in) begin
            cnt_ff <= (cnt_ff >= limit) ? 3'h0 : cnt_ff + 3'h1;
        end
    end
endmodule
`default_nettype wire

// ---- core/timer16.sv ----
// Purpose: 16-bit timer/counter with low-power oscillator control
// Assumes: wishbone classic slave, one clock, pins synchronous
// Notes:   answers every access one cycle after the request
//
// Behaviour
// - 16-bit count, overflow event at wrap
// - both count bytes readable and writable
// - count advances only while run bit set
// - internal source counts every instruction cycle
// - external source counts pin or oscillator edges
// - prescaler ratios 1:1 1:2 1:4 1:8
// - external clock synchronised unless bypass set
// - timer, sync counter, async counter modes
// - wide mode gives 16-bit register access
// - oscillator amplifier runs only when enabled
// - enabled oscillator forces pins input, reads zero
// - compare triggers clear the count, except in async mode
// - oscillator keeps running in sleep, low rate
// - overflow latched, interrupt only when enabled
// - wide mode low read snapshots high byte
// - wide mode high write buffered until low write
// - low write clears prescaler, beats trigger
//
// Implementation choices: the Wishbone interface to the registers and the register offsets.
`default_nettype none
module timer16
    import tc16_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire wb_req_t    wb_req,
    output wb_rsp_t         wb_rsp,
    input  wire logic       trigger_one,
    input  wire logic       trigger_two,
    input  wire logic       osc_input_pin_i,
    input  wire logic       ext_clock_pin_i,
    input  wire logic [1:0] port_direction_bits,
    input  wire logic [1:0] port_latch,
    output logic [1:0]      pin_o,
    output logic [1:0]      pin_oe,
    output logic [1:0]      port_read,
    output logic            osc_amp_enable,
    output logic            overflow_irq
);
    // one count fed by a chosen tick source
    // prescaler in front, register file behind
    // narrow reads may tear across a carry;
    // wide mode with low byte first avoids it
    // the status register is a local addition
    // holding the flag and its enable
    // trade-off: triggers are ignored in async
    // mode rather than risk a half-cleared count
    // registers
    logic [7:0]  control_ff;     // counter_control
    logic [15:0] count_ff;       // live count
    logic [7:0]  hbuf_ff;        // high byte buffer for wide mode
    logic        flag_ff;        // overflow_flag
    logic        irq_en_ff;      // overflow_irq_enable
    logic        ack_ff;         // bus answer
    logic [31:0] rdat_ff;        // read data
    logic [1:0]  div_ff;         // instruction cycle divider

    // decoded control fields
    logic        counter_run;
    logic        clock_source_select;
    logic        ext_clock_sync_bypass;
    logic        low_power_osc_enable;
    logic [1:0]  input_prescale_select;
    logic        wide_access_mode;
    mode_t       mode;

    // bus decode
    logic        req;            // request standing
    logic        rd_take;        // edge at which read data is built
    logic        wr_take;        // edge at which a write takes effect
    logic        wr_low;
    logic        wr_high;
    logic        wr_ctrl;
    logic        wr_stat;
    logic        rd_low;
    logic [7:0]  wdat;
    logic [31:0] nxt_rdat;

    // tick chain
    logic        instr_tick;     // one pulse per instruction cycle
    logic        src_pin;        // selected external source level
    logic        ext_rise;       // external rising edge
    logic        src_tick;       // chosen source tick, gated by run
    logic        cnt_tick;       // prescaled tick into the counter
    logic        trig;           // special event trigger
    logic        overflow;       // wrap from max to zero
    logic [15:0] nxt_count;

    assign counter_run           = control_ff[BIT_RUN];
    assign clock_source_select   = control_ff[BIT_CSEL];
    assign ext_clock_sync_bypass = control_ff[BIT_NSYNC];
    assign low_power_osc_enable  = control_ff[BIT_OSCEN];
    assign input_prescale_select = control_ff[BIT_PS_HI:BIT_PS_LO];
    assign wide_access_mode      = control_ff[BIT_WIDE];

    // three modes from two control bits
    // mode from source select and bypass bit
    always_comb begin
        if (!clock_source_select) begin
            mode = MODE_TIMER;
        end else if (ext_clock_sync_bypass) begin
            mode = MODE_ASYNC;
        end else begin
            mode = MODE_SYNC;
        end
    end

    // ---------------- bus slave ----------------
    // a request is taken with no ack pending
    // ack follows one cycle later, then drops
    // reads latch at the taking edge
    // writes act at the ack edge
    // one fixed wait state keeps decode small
    // only byte lane 0 is decoded
    assign req     = wb_req.cyc & wb_req.stb;
    assign rd_take = req & ~ack_ff & ~wb_req.we;
    assign wr_take = req & ack_ff & wb_req.we & wb_req.sel[0];
    assign wdat    = wb_req.dat[7:0];
    assign wr_low  = wr_take & (wb_req.adr == ADR_LOW);
    assign wr_high = wr_take & (wb_req.adr == ADR_HIGH);
    assign wr_ctrl = wr_take & (wb_req.adr == ADR_CONTROL);
    assign wr_stat = wr_take & (wb_req.adr == ADR_STATUS);
    assign rd_low  = rd_take & (wb_req.adr == ADR_LOW);

    // an unmapped access still gets its ack
    // ack one cycle after the request, dropped the cycle after
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_ff <= 1'b0;
        end else begin
            ack_ff <= req & ~ack_ff;
        end
    end

    // read mux; unmapped addresses read zero but still answer
    // whole bytes can be tested without masks
    always_comb begin
        nxt_rdat = 32'h0000_0000;
        case (wb_req.adr)
            ADR_CONTROL: begin
                // bit 6 is never stored, so it reads zero
                nxt_rdat[7:0] = control_ff;
            end
            ADR_LOW: begin
                nxt_rdat[7:0] = count_ff[7:0];
            end
            ADR_HIGH: begin
                // wide mode shows the buffer, not the live byte
                nxt_rdat[7:0] = wide_access_mode ? hbuf_ff
                                : count_ff[15:8];
            end
            ADR_STATUS: begin
                nxt_rdat[BIT_FLAG] = flag_ff;
                nxt_rdat[BIT_IEN]  = irq_en_ff;
            end
            default: begin
                nxt_rdat = 32'h0000_0000;
            end
        endcase
    end

    // read data is built at the request edge and held with ack
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rdat_ff <= 32'h0000_0000;
        end else if (rd_take) begin
            rdat_ff <= nxt_rdat;
        end
    end

    assign wb_rsp.ack = ack_ff;
    assign wb_rsp.dat = rdat_ff;

    // control register; the unimplemented bit is masked off
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            control_ff <= CONTROL_RST;
        end else if (wr_ctrl) begin
            control_ff <= wdat & CONTROL_WR_MASK;
        end
    end

    // in narrow mode the buffer is idle
    // high byte buffer: snapshot on low read, target of high write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hbuf_ff <= BYTE_RST;
        end else if (wide_access_mode && wr_high) begin
            hbuf_ff <= wdat;
        end else if (wide_access_mode && rd_low) begin
            // same edge that samples the low byte, so both agree
            hbuf_ff <= count_ff[15:8];
        end
    end

    // ---------------- tick sources ----------------
    // free divider: first timer tick comes
    // one to four cycles after the run write
    // external source is the pin, or the
    // crystal input while the oscillator runs
    // a bypassed pin must meet setup to clk
    // free-running divide by four for the instruction clock
    // wraps every four clocks, never stopped
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            div_ff <= 2'h0;
        end else begin
            div_ff <= div_ff + 2'h1;
        end
    end
    assign instr_tick = (div_ff == INSTR_LAST);

    // the enabled oscillator replaces the external pin as source
    assign src_pin = low_power_osc_enable ? osc_input_pin_i
                     : ext_clock_pin_i;

    // the synchroniser costs two cycles of latency
    // bypass only matters when the external source is chosen
    edge_sync u_edge_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .pin     (src_pin),
        .bypass  (mode == MODE_ASYNC),
        .rise    (ext_rise)
    );

    // source choice, stopped while the run bit is clear
    always_comb begin
        case (mode)
            MODE_TIMER: src_tick = counter_run & instr_tick;
            MODE_SYNC:  src_tick = counter_run & ext_rise;
            MODE_ASYNC: src_tick = counter_run & ext_rise;
            default:    src_tick = 1'b0;
        endcase
    end

    // the prescaler is not visible to software
    // any low-byte write restarts the prescaler; high writes do not
    prescale_div u_prescale_div (
        .clk      (clk),
        .reset_n  (reset_n),
        .tick_in  (src_tick),
        .ratio    (input_prescale_select),
        .clear    (wr_low),
        .tick_out (cnt_tick)
    );

    // ---------------- counter ----------------
    // priority: low write, narrow high write,
    // wide high write (hold), trigger, tick
    // a trigger held high pins the count at zero
    // only a real wrap raises the flag
    // a wide high write costs one lost tick
    // in exchange for a simple hold path
    // the trigger is unreliable in async mode, so it is not honoured
    assign trig = (trigger_one | trigger_two)
                  & (mode != MODE_ASYNC);

    // only a real increment past max counts as overflow
    assign overflow = cnt_tick & (count_ff == COUNT_MAX)
                      & ~wr_low & ~wr_high & ~trig;

    // write beats trigger, trigger beats increment
    always_comb begin
        nxt_count = count_ff;
        if (wr_low) begin
            // wide mode loads all 16 bits at once
            nxt_count = wide_access_mode ? {hbuf_ff, wdat}
                        : {count_ff[15:8], wdat};
        end else if (wr_high && !wide_access_mode) begin
            nxt_count = {wdat, count_ff[7:0]};
        end else if (wr_high) begin
            nxt_count = count_ff;
        end else if (trig) begin
            nxt_count = COUNT_RST;
        end else if (cnt_tick) begin
            nxt_count = count_ff + 16'h0001;
        end
    end

    // no enable: the next value is always built
    // the count register itself
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count_ff <= COUNT_RST;
        end else begin
            count_ff <= nxt_count;
        end
    end

    // ---------------- overflow flag ----------------
    // flag is sticky until a one is written
    // set beats clear so no event is lost
    // software clears by writing one; a coincident overflow wins
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_ff <= 1'b0;
        end else if (overflow) begin
            flag_ff <= 1'b1;
        end else if (wr_stat && wdat[BIT_FLAG]) begin
            flag_ff <= 1'b0;
        end
    end

    // interrupt enable lives beside the flag
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            irq_en_ff <= 1'b0;
        end else if (wr_stat) begin
            irq_en_ff <= wdat[BIT_IEN];
        end
    end

    // irq is a level, not a pulse
    // request only while enabled; trigger resets never set the flag
    assign overflow_irq = flag_ff & irq_en_ff;

    // ---------------- oscillator pins ----------------
    // enabled oscillator owns both pads
    // stray port writes cannot load the crystal
    // no state here, only masking
    // sleep is not modelled: the enable bit
    // alone decides whether the amplifier runs
    // amplifier follows the enable bit alone; no sleep gating here,
    // so the crystal keeps running while the core sleeps
    assign osc_amp_enable = low_power_osc_enable;

    // enabled oscillator owns the pins: no drive, port reads zero
    always_comb begin
        if (low_power_osc_enable) begin
            pin_oe    = 2'h0;
            pin_o     = 2'h0;
            port_read = 2'h0;
        end else begin
            // direction bit one means input, as for a normal port
            pin_oe    = ~port_direction_bits;
            pin_o     = port_latch;
            port_read = {ext_clock_pin_i, osc_input_pin_i};
        end
    end
endmodule
`default_nettype wire

// ---- testbench/timer16_properties.sv ----
// Purpose: port-level checks of timer16
// Assumes: sees only the top ports; one clock domain
// Notes:   count values are judged by the bench, not here
`default_nettype none
module timer16_properties
    import tc16_pkg::*;
(
    input wire logic       clk,
    input wire logic       reset_n,
    input wire wb_req_t    wb_req,
    input wire wb_rsp_t    wb_rsp,
    input wire logic       osc_input_pin_i,
    input wire logic       ext_clock_pin_i,
    input wire logic [1:0] port_direction_bits,
    input wire logic [1:0] pin_oe,
    input wire logic [1:0] port_read,
    input wire logic       osc_amp_enable,
    input wire logic       overflow_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    // a request is taken when no answer is pending
    sequence s_take;
        wb_req.cyc && wb_req.stb && !wb_rsp.ack;
    endsequence
    // read of one address taken
    sequence s_read(a);
        s_take ##0 (!wb_req.we && wb_req.adr == a);
    endsequence
    property p_ack_one;
        s_take |=> wb_rsp.ack;
    endproperty
    a_ack_one: assert property (p_ack_one)
        else $error("ack missing one cycle after request");
    property p_ack_drop;
        wb_rsp.ack |=> !wb_rsp.ack;
    endproperty
    a_ack_drop: assert property (p_ack_drop)
        else $error("ack held longer than one cycle");
    // unmapped space reads as zero
    property p_unmapped;
        s_take ##0 (!wb_req.we && wb_req.adr > ADR_STATUS)
            |=> wb_rsp.dat == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read returned nonzero");
    property p_bit6;
        s_read(ADR_CONTROL) |=> !wb_rsp.dat[BIT_UNIMP];
    endproperty
    a_bit6: assert property (p_bit6)
        else $error("control bit 6 read as one");
    // amplifier only moves on a control write
    property p_osc_amp;
        $changed(osc_amp_enable) |->
            $past(wb_req.cyc && wb_req.we && wb_req.adr == ADR_CONTROL);
    endproperty
    a_osc_amp: assert property (p_osc_amp)
        else $error("oscillator enable moved without control write");
    property p_pins_osc;
        osc_amp_enable |-> pin_oe == 2'h0 && port_read == 2'h0;
    endproperty
    a_pins_osc: assert property (p_pins_osc)
        else $error("oscillator pins not forced to input");
    property p_pins_off;
        !osc_amp_enable |-> pin_oe == ~port_direction_bits &&
            port_read == {ext_clock_pin_i, osc_input_pin_i};
    endproperty
    a_pins_off: assert property (p_pins_off)
        else $error("port pins wrong with oscillator off");
    // only software takes a pending request down
    property p_irq_fall;
        $fell(overflow_irq) |-> $past(wb_req.cyc && wb_req.we);
    endproperty
    a_irq_fall: assert property (p_irq_fall)
        else $error("irq dropped without a write");
endmodule
bind timer16 timer16_properties i_props (
    .clk                 (clk),
    .reset_n             (reset_n),
    .wb_req              (wb_req),
    .wb_rsp              (wb_rsp),
    .osc_input_pin_i     (osc_input_pin_i),
    .ext_clock_pin_i     (ext_clock_pin_i),
    .port_direction_bits (port_direction_bits),
    .pin_oe              (pin_oe),
    .port_read           (port_read),
    .osc_amp_enable      (osc_amp_enable),
    .overflow_irq        (overflow_irq)
);
`default_nettype wire

// ---- testbench/clock_source.sv ----
// Purpose: external clock source and crystal stand-in
// Assumes: bursts are commanded by the bench
// Notes:   both lines rest low between bursts, no free run
`default_nettype none
module clock_source (
    input  wire logic clk,
    output logic      osc_line,
    output logic      ext_line
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        osc_line = 1'b0;
        ext_line = 1'b0;
    end
    // n rising edges, half period in system clocks; far faster
    // than a watch crystal to keep the run short
    task automatic burst(input bit use_osc, input int n, input int half);
        for (int i = 0; i < n; i++) begin
            @(posedge clk);
            if (use_osc) osc_line <= 1'b1;
            else ext_line <= 1'b1;
            repeat (half) @(posedge clk);
            osc_line <= 1'b0;
            ext_line <= 1'b0;
            repeat (half - 1) @(posedge clk);
        end
    endtask
endmodule
`default_nettype wire

// ---- testbench/tb.sv ----
// Purpose: self-checking bench for timer16
// Assumes: wishbone classic master tasks, one clock
// Notes:   timer counts are accepted within one tick of ideal
`default_nettype none
module tb
    import tc16_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic       clk;             // system clock
    logic       reset_n;         // async reset, low active
    wb_req_t    wb_req;          // bus request
    wb_rsp_t    wb_rsp;          // bus answer
    logic [1:0] trig;            // compare triggers {two, one}
    logic       osc_line;        // crystal pin
    logic       ext_line;        // external clock pin
    logic [1:0] pin_oe;          // pin drive enables
    logic [1:0] pin_o;           // pin drive values
    logic [1:0] pdir;            // port direction, 1 = input
    logic [1:0] port_read;       // pin read values
    logic       osc_amp;         // amplifier enable
    logic       irq;             // overflow request
    logic [7:0] rd;              // last read byte
    logic       ok;              // range result
    int         e;               // ideal count
    int         cycles;          // timeout counter
    int         n_mismatch;
    int         samples_checked;
    logic [7:0] adrs [4] = '{ADR_CONTROL, ADR_LOW, ADR_HIGH, ADR_STATUS};
    logic [7:0] modes [3] = '{8'h03, 8'h07, 8'h0b};

    timer16 i_dut (
        .clk                 (clk),
        .reset_n             (reset_n),
        .wb_req              (wb_req),
        .wb_rsp              (wb_rsp),
        .trigger_one         (trig[0]),
        .trigger_two         (trig[1]),
        .osc_input_pin_i     (osc_line),
        .ext_clock_pin_i     (ext_line),
        .port_direction_bits (pdir),
        .port_latch          (2'b10),
        .pin_o               (pin_o),
        .pin_oe              (pin_oe),
        .port_read           (port_read),
        .osc_amp_enable      (osc_amp),
        .overflow_irq        (irq)
    );
    clock_source i_src (.clk(clk), .osc_line(osc_line), .ext_line(ext_line));

    initial clk = 1'b0;
    always #2.5 clk = ~clk;
    // cut a hang short
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one classic cycle; trigger may be held across it
    task automatic bus(input logic we, input logic [7:0] adr,
                       input logic [7:0] d, input logic [1:0] t);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, adr, 4'h1, {24'h0, d}};
        trig <= t;
        do @(posedge clk); while (wb_rsp.ack !== 1'b1);
        rd = wb_rsp.dat[7:0];
        wb_req <= '0;
        trig <= 2'b00;
    endtask
    task automatic wr(input logic [7:0] adr, input logic [7:0] d);
        bus(1'b1, adr, d, 2'b00);
    endtask
    task automatic rc(input logic [7:0] adr, input logic [7:0] exp);
        bus(1'b0, adr, 8'h00, 2'b00);
        check(16'(rd), 16'(exp));
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    initial begin
        cycles = 0;
        n_mismatch = 0;
        samples_checked = 0;
        pdir = 2'b01;
        wb_req = '0;
        trig = 2'b00;
        reset_n = 1'b0;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        foreach (adrs[i]) rc(adrs[i], 8'h00);
        check(16'(pin_oe), 16'h2);
        check(16'(pin_o), 16'h2);
        pdir <= 2'b10;
        @(posedge clk);
        check(16'(pin_oe), 16'h1);
        pdir <= 2'b01;
        wr(ADR_CONTROL, 8'hff);
        rc(ADR_CONTROL, 8'hbf);
        wr(ADR_CONTROL, 8'h00);
        wr(8'h10, 8'hff);
        rc(8'h10, 8'h00);
        // timer mode at every prescale ratio
        for (int p = 0; p < 4; p++) begin
            wr(ADR_HIGH, 8'h00);
            wr(ADR_LOW, 8'h00);
            wr(ADR_CONTROL, 8'(p << 4) | 8'h01);
            repeat (320) @(posedge clk);
            wr(ADR_CONTROL, 8'h00);
            e = 323 / (4 << p);
            bus(1'b0, ADR_LOW, 8'h00, 2'b00);
            ok = (rd + 1 >= e) && (rd <= e + 1);
            check(16'(ok), 16'h1);
        end
        repeat (40) @(posedge clk);
        rc(ADR_LOW, rd);
        // overflow raised, masked and cleared
        wr(ADR_STATUS, 8'h02);
        for (int k = 0; k < 2; k++) begin
            wr(ADR_HIGH, 8'hff);
            wr(ADR_LOW, 8'hf0);
            wr(ADR_CONTROL, 8'h01);
            repeat (100) @(posedge clk);
            wr(ADR_CONTROL, 8'h00);
            rc(ADR_HIGH, 8'h00);
            rc(ADR_STATUS, k ? 8'h01 : 8'h03);
            check(16'(irq), k ? 16'h0 : 16'h1);
            wr(ADR_STATUS, 8'h01);
            rc(ADR_STATUS, 8'h00);
        end
        wr(ADR_STATUS, 8'h02);
        rc(ADR_STATUS, 8'h02);
        check(16'(irq), 16'h0);
        // 16-bit access through the high byte buffer
        wr(ADR_HIGH, 8'haa);
        wr(ADR_LOW, 8'h78);
        wr(ADR_CONTROL, 8'h80);
        wr(ADR_HIGH, 8'h11);
        wr(ADR_CONTROL, 8'h00);
        rc(ADR_HIGH, 8'haa);
        wr(ADR_CONTROL, 8'h80);
        wr(ADR_LOW, 8'h22);
        rc(ADR_LOW, 8'h22);
        rc(ADR_HIGH, 8'h11);
        wr(ADR_HIGH, 8'h33);
        rc(ADR_HIGH, 8'h33);
        wr(ADR_CONTROL, 8'h00);
        rc(ADR_HIGH, 8'h11);
        // each compare trigger clears the count
        for (int k = 0; k < 2; k++) begin
            wr(ADR_HIGH, 8'h12);
            wr(ADR_LOW, 8'h34);
            @(posedge clk) trig <= 2'(1 << k);
            @(posedge clk) trig <= 2'b00;
            rc(ADR_LOW, 8'h00);
            rc(ADR_HIGH, 8'h00);
        end
        rc(ADR_STATUS, 8'h02);
        bus(1'b1, ADR_LOW, 8'h5a, 2'b01);
        rc(ADR_LOW, 8'h5a);
        // sync, async and oscillator counting
        foreach (modes[m]) begin
            wr(ADR_HIGH, 8'h00);
            wr(ADR_LOW, 8'h00);
            wr(ADR_CONTROL, modes[m]);
            @(posedge clk);
            if (m == 2) begin
                check(16'({osc_amp, pin_o, pin_oe, port_read}), 16'h40);
                repeat (50) @(posedge clk); // start-up wait
            end
            i_src.burst(m == 2, 5, 4);
            repeat (10) @(posedge clk);
            wr(ADR_CONTROL, 8'h00);
            rc(ADR_LOW, 8'h05);
        end
        // prescaler kept by high writes, cleared by low writes
        wr(ADR_LOW, 8'h00);
        wr(ADR_CONTROL, 8'h33);
        i_src.burst(1'b0, 5, 2);
        wr(ADR_HIGH, 8'h00);
        i_src.burst(1'b0, 3, 2);
        repeat (4) @(posedge clk);
        rc(ADR_LOW, 8'h01);
        i_src.burst(1'b0, 4, 2);
        wr(ADR_LOW, 8'h00);
        i_src.burst(1'b0, 7, 2);
        repeat (4) @(posedge clk);
        rc(ADR_LOW, 8'h00);
        finish_test();
    end
endmodule
`default_nettype wire
